// ---- hw/flash_ctrl_dev.sv ----
// Notes on behaviour
// - programming only clears bits, never sets
// - 80 pages of 8 rows of 64 words
// - address: page 15:9, row 8:6, word 5:0
// - each word programmed twice at most per erase; not enforced, every program command is carried out
// - page erase address has low nine bits zero
// - code 0x11 erases the addressed page
// - erased page reads all ones
// - code 0x22 erases the whole array
// - started flag set when command begins
// - started flag cleared by writing one
// - finished flag set when operation ends
// - finished flag cleared by writing one, after started
// - code 0x33 programs one word
// - code 0xcc programs up to four words
// - burst word n goes to address plus n
// - unused burst words are filled with all ones
// - array words read like ram
// - 32-bit reads, single and 4-word programming
// - fetches and data reads share one slave port
// - reserved fields written with reset value
// - finished at bit 0, started at bit 1
// - command while busy sets error bit 2
// - unknown code sets error bit 3
module flash_ctrl_dev (
  input  wire logic                       mclk_i,    // 25 MHz clock
  input  wire logic                       arst_n_i,  // async reset, active low
  flash_link_if.dev                       link,      // register and array port
  output logic                            busy_o,    // operation running
  output logic [flash_pkg::NUM_FLAGS-1:0] flags_o    // event flags
);
  import flash_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_DWELL} op_state_t;

  // ---------------------------------------------------------------
  // storage and state
  // ---------------------------------------------------------------
  logic [31:0]          mem [0:ARRAY_WORDS-1];
  op_state_t            state_ff;
  logic                 ack_ff;
  logic [31:0]          rdata_ff;
  logic [15:0]          address_ff;
  logic [31:0]          data_ff [0:3];
  logic [NUM_FLAGS-1:0] flags_ff;
  logic [15:0]          cur_ff;
  logic [15:0]          last_ff;
  logic [1:0]           slot_ff;
  logic                 burst_ff;
  logic [10:0]          dwell_ff;

  function automatic logic cmd_known(input logic [7:0] code);
    cmd_known = (code == CMD_PAGE_CLEAR) || (code == CMD_FULL_CLEAR) ||
                (code == CMD_ONE_WORD) || (code == CMD_MULTI_WORD);
  endfunction : cmd_known

  function automatic logic [31:0] reg_read(input logic [7:0] ofs, input logic [NUM_FLAGS-1:0] flg,
                                           input logic [15:0] adr, input logic [31:0] dat [0:3]);
    reg_read = 32'h0000_0000;
    if (ofs == OFS_EVENTS) begin
      reg_read = 32'(flg);
    end else if (ofs == OFS_SIZE) begin
      reg_read = SIZE_VALUE;
    end else if (ofs == OFS_ADDRESS) begin
      reg_read = 32'(adr);
    end else if (ofs >= OFS_PROGRAM_WORD_FIRST && ofs <= OFS_DATA3 && ofs[1:0] == 2'b00) begin
      reg_read = dat[ofs[3:2]];
    end
  endfunction : reg_read

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  logic        idle;
  logic        take;
  logic        reg_wr;
  logic        cmd_wr;
  logic        launch;
  logic [7:0]  ofs;
  logic [15:0] tgt;
  logic [31:0] word;
  logic        skip;
  logic        advance;
  logic        last_slot;
  logic        finish;

  assign idle      = (state_ff == ST_IDLE);
  // array reads stall until the array is free again; registers never stall
  assign take      = link.req_valid && !ack_ff && (link.req_reg || idle);
  assign ofs       = link.req_addr[7:0];
  assign reg_wr    = take && link.req_write && link.req_reg;
  assign cmd_wr    = reg_wr && (ofs == OFS_COMMAND);
  assign launch    = cmd_wr && idle && cmd_known(link.req_wdata[7:0]);
  assign tgt       = address_ff + 16'(slot_ff);
  assign word      = data_ff[slot_ff];
  // all-ones words carry nothing to program, so a burst steps over them
  assign skip      = burst_ff && (word == ERASED_WORD);
  assign last_slot = !burst_ff || (slot_ff == 2'd3);
  assign advance   = (state_ff == ST_PROG && skip) || (state_ff == ST_DWELL && dwell_ff == 11'd0);
  assign finish    = (state_ff == ST_ERASE && cur_ff == last_ff) || (advance && last_slot);

  // ---------------------------------------------------------------
  // bus answer: one ack per request, reads sampled as ram
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= take;
      if (take && !link.req_write) begin
        if (link.req_reg) begin
          rdata_ff <= reg_read(ofs, flags_ff, address_ff, data_ff);
        end else if (link.req_addr <= LAST_WORD) begin
          rdata_ff <= mem[link.req_addr];
        end else begin
          rdata_ff <= 32'h0000_0000;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // address and data registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      address_ff <= ADDRESS_RST;
      for (int i = 0; i < 4; i++) begin
        data_ff[i] <= DATA_RESET;
      end
    end else if (reg_wr) begin
      // writes are refused while busy so an operation keeps its operands
      if (ofs == OFS_ADDRESS && idle) begin
        address_ff <= link.req_wdata[15:0];
      end
      if (ofs >= OFS_PROGRAM_WORD_FIRST && ofs <= OFS_DATA3 && ofs[1:0] == 2'b00 && idle) begin
        data_ff[ofs[3:2]] <= link.req_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // event flags: a set in the cycle of its clear wins
  // ---------------------------------------------------------------
  logic [NUM_FLAGS-1:0] flg_set;
  logic [NUM_FLAGS-1:0] flg_clr;

  always_comb begin
    flg_set              = '0;
    flg_set[FLG_STARTED] = launch;
    flg_set[FLG_DONE]    = finish;
    flg_set[FLG_ACT_ERR] = cmd_wr && !idle;
    flg_set[FLG_UNKNOWN] = cmd_wr && !cmd_known(link.req_wdata[7:0]);
    flg_clr              = (reg_wr && ofs == OFS_EVENTS) ? link.req_wdata[NUM_FLAGS-1:0] : '0;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= (flags_ff & ~flg_clr) | flg_set;
    end
  end

  // ---------------------------------------------------------------
  // operation sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= ST_IDLE;
      cur_ff   <= 16'h0000;
      last_ff  <= 16'h0000;
      slot_ff  <= 2'd0;
      burst_ff <= 1'b0;
      dwell_ff <= 11'd0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (launch) begin
            slot_ff  <= 2'd0;
            burst_ff <= (link.req_wdata[7:0] == CMD_MULTI_WORD);
            if (link.req_wdata[7:0] == CMD_PAGE_CLEAR) begin
              cur_ff   <= {address_ff[15:PAGE_LSB], {PAGE_LSB{1'b0}}};
              last_ff  <= {address_ff[15:PAGE_LSB], {PAGE_LSB{1'b0}}} + PAGE_SPAN;
              state_ff <= ST_ERASE;
            end else if (link.req_wdata[7:0] == CMD_FULL_CLEAR) begin
              cur_ff   <= 16'h0000;
              last_ff  <= LAST_WORD;
              state_ff <= ST_ERASE;
            end else begin
              state_ff <= ST_PROG;
            end
          end
        end
        ST_ERASE: begin
          if (cur_ff == last_ff) begin
            state_ff <= ST_IDLE;
          end else begin
            cur_ff <= cur_ff + 16'h0001;
          end
        end
        ST_PROG: begin
          if (!skip) begin
            dwell_ff <= PROG_DWELL;
            state_ff <= ST_DWELL;
          end else if (last_slot) begin
            state_ff <= ST_IDLE;
          end else begin
            slot_ff <= slot_ff + 2'd1;
          end
        end
        ST_DWELL: begin
          if (dwell_ff != 11'd0) begin
            dwell_ff <= dwell_ff - 11'd1;
          end else if (last_slot) begin
            state_ff <= ST_IDLE;
          end else begin
            slot_ff  <= slot_ff + 2'd1;
            state_ff <= ST_PROG;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // array writes; no reset, the array keeps its contents
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (state_ff == ST_ERASE && cur_ff <= LAST_WORD) begin
      mem[cur_ff] <= ERASED_WORD;
    end else if (state_ff == ST_PROG && !skip && tgt <= LAST_WORD) begin
      // and-ing means a one can never come back without an erase
      mem[tgt] <= mem[tgt] & word;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_o  <= 1'b0;
      flags_o <= '0;
    end else begin
      busy_o  <= launch || (!idle && !finish);
      flags_o <= (flags_ff & ~flg_clr) | flg_set;
    end
  end

  assign link.ack   = ack_ff;
  assign link.rdata = rdata_ff;
endmodule : flash_ctrl_dev

// ---- hw/flash_host.sv ----
module flash_host (
  input  wire logic        mclk_i,            // 25 MHz clock
  input  wire logic        arst_n_i,          // async reset, active low
  flash_link_if.host       link,              // toward the flash controller
  input  wire logic [7:0]  s_axi_awaddr_i,    // write address
  input  wire logic        s_axi_awvalid_i,   // write address valid
  output logic             s_axi_awready_o,   // write address ready
  input  wire logic [31:0] s_axi_wdata_i,     // write data
  input  wire logic [3:0]  s_axi_wstrb_i,     // byte strobes
  input  wire logic        s_axi_wvalid_i,    // write data valid
  output logic             s_axi_wready_o,    // write data ready
  output logic [1:0]       s_axi_bresp_o,     // write response
  output logic             s_axi_bvalid_o,    // write response valid
  input  wire logic        s_axi_bready_i,    // write response ready
  input  wire logic [7:0]  s_axi_araddr_i,    // read address
  input  wire logic        s_axi_arvalid_i,   // read address valid
  output logic             s_axi_arready_o,   // read address ready
  output logic [31:0]      s_axi_rdata_o,     // read data
  output logic [1:0]       s_axi_rresp_o,     // read response
  output logic             s_axi_rvalid_o,    // read data valid
  input  wire logic        s_axi_rready_i     // read data ready
);
  import flash_pkg::*;

  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [16:0] target_ff;
  logic [31:0] out_data_ff;
  logic [31:0] in_data_ff;
  logic        done_ff;
  logic        req_valid_ff;
  logic        req_write_ff;

  // ---------------------------------------------------------------
  // write channel: address and data in either order
  // ---------------------------------------------------------------
  logic do_write;
  logic go;
  logic mapped_w;
  assign do_write = aw_got_ff && w_got_ff && !s_axi_bvalid_o;
  assign mapped_w = (awaddr_ff == H_OFS_TARGET) || (awaddr_ff == H_OFS_WDATA) ||
                    (awaddr_ff == H_OFS_CTRL) || (awaddr_ff == H_OFS_STATUS);
  assign go       = do_write && awaddr_ff == H_OFS_CTRL && wdata_ff[CTL_GO] && !req_valid_ff;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
      aw_got_ff       <= 1'b0;
      w_got_ff        <= 1'b0;
      awaddr_ff       <= 8'h00;
      wdata_ff        <= 32'h0000_0000;
      wstrb_ff        <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        awaddr_ff       <= s_axi_awaddr_i;
        aw_got_ff       <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wdata_ff       <= s_axi_wdata_i;
        wstrb_ff       <= s_axi_wstrb_i;
        w_got_ff       <= 1'b1;
        s_axi_wready_o <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= mapped_w ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        aw_got_ff       <= 1'b0;
        w_got_ff        <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // order registers; partial strobes are not merged, a full word is expected
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      target_ff   <= 17'h0_0000;
      out_data_ff <= 32'h0000_0000;
    end else if (do_write && wstrb_ff != 4'h0) begin
      if (awaddr_ff == H_OFS_TARGET) begin
        target_ff <= wdata_ff[16:0];
      end
      if (awaddr_ff == H_OFS_WDATA) begin
        out_data_ff <= wdata_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // link request: held until the controller acks
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_valid_ff <= 1'b0;
      req_write_ff <= 1'b0;
      in_data_ff   <= 32'h0000_0000;
      done_ff      <= 1'b0;
    end else begin
      if (go) begin
        req_valid_ff <= 1'b1;
        req_write_ff <= wdata_ff[CTL_WRITE];
      end else if (req_valid_ff && link.ack) begin
        req_valid_ff <= 1'b0;
        if (!req_write_ff) begin
          in_data_ff <= link.rdata;
        end
      end
      // completion set wins over a software clear in the same cycle
      if (req_valid_ff && link.ack) begin
        done_ff <= 1'b1;
      end else if (do_write && awaddr_ff == H_OFS_STATUS && wdata_ff[STS_DONE]) begin
        done_ff <= 1'b0;
      end
    end
  end

  assign link.req_valid = req_valid_ff;
  assign link.req_write = req_write_ff;
  assign link.req_reg   = target_ff[TGT_REG_BIT];
  assign link.req_addr  = target_ff[15:0];
  assign link.req_wdata = out_data_ff;

  // ---------------------------------------------------------------
  // read channel: answer one cycle after the address
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rresp_o   <= RESP_OKAY;
      unique case (s_axi_araddr_i)
        H_OFS_TARGET: s_axi_rdata_o <= 32'(target_ff);
        H_OFS_WDATA:  s_axi_rdata_o <= out_data_ff;
        H_OFS_CTRL:   s_axi_rdata_o <= 32'h0000_0000;
        H_OFS_RDATA:  s_axi_rdata_o <= in_data_ff;
        H_OFS_STATUS: s_axi_rdata_o <= {30'h0, done_ff, req_valid_ff};
        default: begin
          s_axi_rdata_o <= 32'h0000_0000;
          s_axi_rresp_o <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end
endmodule : flash_host

// ---- hw/flash_link_if.sv ----
interface flash_link_if;
  logic        req_valid;  // request held until ack
  logic        req_write;  // 1 write, 0 read
  logic        req_reg;    // 1 register space, 0 array
  logic [15:0] req_addr;   // word address or register byte offset
  logic [31:0] req_wdata;  // write data
  logic        ack;        // one-cycle answer
  logic [31:0] rdata;      // read data, valid with ack

  modport dev  (input req_valid, req_write, req_reg, req_addr, req_wdata, output ack, rdata);
  modport host (output req_valid, req_write, req_reg, req_addr, req_wdata, input ack, rdata);
endinterface : flash_link_if

// ---- hw/flash_pkg.sv ----
package flash_pkg;
  // --------------
  // array geometry
  // --------------
  localparam int          NUM_PAGES    = 80;
  localparam int          PAGE_ROWS    = 8;
  localparam int          ROW_WORDS    = 64;
  localparam int          PAGE_WORDS   = PAGE_ROWS * ROW_WORDS;
  localparam int          ARRAY_WORDS  = NUM_PAGES * PAGE_WORDS;
  localparam int          ADDR_W       = 16;
  localparam int          PAGE_LSB     = 9;
  localparam int          ROW_LSB      = 6;
  localparam logic [31:0] ERASED_WORD  = 32'hffff_ffff;
  localparam logic [15:0] LAST_WORD    = 16'(ARRAY_WORDS - 1);
  localparam logic [15:0] PAGE_SPAN    = 16'(PAGE_WORDS - 1);

  // --------------
  // command codes
  // --------------
  localparam logic [7:0]  CMD_PAGE_CLEAR = 8'h11;
  localparam logic [7:0]  CMD_FULL_CLEAR = 8'h22;
  localparam logic [7:0]  CMD_ONE_WORD   = 8'h33;
  localparam logic [7:0]  CMD_MULTI_WORD = 8'hcc;

  // --------------
  // device register offsets, fields and reset values
  // --------------
  localparam logic [7:0]  OFS_COMMAND  = 8'h00;
  localparam logic [7:0]  OFS_EVENTS   = 8'h08;
  localparam logic [7:0]  OFS_SIZE     = 8'h14;
  localparam logic [7:0]  OFS_ADDRESS  = 8'h18;
  localparam logic [7:0]  OFS_PROGRAM_WORD_FIRST    = 8'h40;
  localparam logic [7:0]  OFS_DATA3    = 8'h4c;
  localparam int          FLG_DONE     = 0;
  localparam int          FLG_STARTED  = 1;
  localparam int          FLG_ACT_ERR  = 2;
  localparam int          FLG_UNKNOWN  = 3;
  localparam int          NUM_FLAGS    = 4;
  localparam logic [31:0] SIZE_VALUE   = 32'h0000_9fff;
  localparam logic [31:0] DATA_RESET   = 32'hffff_ffff;
  localparam logic [15:0] ADDRESS_RST  = 16'h0000;

  // --------------
  // timing
  // --------------
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          PROG_TIME_NS  = 44000;
  localparam int          PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam logic [10:0] PROG_DWELL    = 11'(PROG_CYCLES - 1);

  // --------------
  // host register map (axi4-lite side)
  // --------------
  localparam logic [7:0]  H_OFS_TARGET = 8'h00;
  localparam logic [7:0]  H_OFS_WDATA  = 8'h04;
  localparam logic [7:0]  H_OFS_CTRL   = 8'h08;
  localparam logic [7:0]  H_OFS_RDATA  = 8'h0c;
  localparam logic [7:0]  H_OFS_STATUS = 8'h10;
  localparam int          TGT_REG_BIT  = 16;
  localparam int          CTL_GO       = 0;
  localparam int          CTL_WRITE    = 1;
  localparam int          STS_BUSY     = 0;
  localparam int          STS_DONE     = 1;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage : flash_pkg

// ---- verif/flash_link_monitor.sv ----
module flash_link_monitor (
  input logic        mclk_i,    // clock
  input logic        arst_n_i,  // async reset, active low
  input logic        req_valid, // request pending
  input logic        req_write, // write request
  input logic        req_reg,   // register space
  input logic [15:0] req_addr,  // address or offset
  input logic [31:0] req_wdata, // write data
  input logic        ack,       // answer pulse
  input logic        busy_o,    // operation running
  input logic [3:0]  flags_o    // event flags
);
  import flash_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // --------------
  // request decode
  // --------------
  logic take, cmd_wr, known;
  // the device takes a request only in a cycle without ack
  assign take   = req_valid && !ack;
  assign cmd_wr = take && req_reg && req_write && req_addr[7:0] == OFS_COMMAND;
  // only the low byte of a command is decoded
  assign known  = req_wdata[7:0] inside {CMD_PAGE_CLEAR, CMD_FULL_CLEAR, CMD_ONE_WORD, CMD_MULTI_WORD};
  // --------------
  // properties
  // --------------
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_req_hold; req_valid && !ack |=> req_valid && $stable(req_addr); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  property p_reg_ack; take && req_reg |=> ack; endproperty
  a_reg_ack: assert property (p_reg_ack) else $error("register not acked");
  property p_read_stall; take && !req_reg && !req_write && busy_o |=> !ack; endproperty
  a_read_stall: assert property (p_read_stall) else $error("read not stalled");
  property p_started; cmd_wr && known && !busy_o |-> ##[1:3] flags_o[FLG_STARTED]; endproperty
  a_started: assert property (p_started) else $error("started flag missing");
  property p_unknown; cmd_wr && !known |-> ##[1:3] flags_o[FLG_UNKNOWN]; endproperty
  a_unknown: assert property (p_unknown) else $error("unknown flag missing");
  property p_cmd_busy; cmd_wr && busy_o |-> ##[1:3] flags_o[FLG_ACT_ERR]; endproperty
  a_cmd_busy: assert property (p_cmd_busy) else $error("busy flag missing");
  property p_clear;
    take && req_reg && req_write && req_addr[7:0] == OFS_EVENTS && req_wdata[FLG_STARTED] && !busy_o
      |-> ##[2:3] !flags_o[FLG_STARTED];
  endproperty
  a_clear: assert property (p_clear) else $error("started flag not cleared");
  property p_done; $fell(busy_o) |-> ##[0:2] flags_o[FLG_DONE]; endproperty
  a_done: assert property (p_done) else $error("done flag missing");
endmodule : flash_link_monitor

// ---- verif/tb_embedded_flash_controller.sv ----
module tb_embedded_flash_controller;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_pkg::*;
  // --------------
  // signals and instances
  // --------------
  localparam logic [15:0] A1    = {7'd3, 3'd2, 6'd5};  // page 3 row 2 word 5
  localparam logic [15:0] A2    = {7'd4, 3'd0, 6'd62}; // burst runs over a row edge
  localparam int          LIMIT = 90000;
  logic        mclk_i, arst_n_i, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, busy;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_seen, resp_seen;
  logic [1:0]  bresp, rresp;
  logic [3:0]  flags;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  flash_link_if link ();
  flash_ctrl_dev u_flash_ctrl_dev (.mclk_i, .arst_n_i, .link, .busy_o(busy), .flags_o(flags));
  flash_host u_flash_host (.mclk_i, .arst_n_i, .link, .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  flash_link_monitor mon (.mclk_i, .arst_n_i, .req_valid(link.req_valid), .req_write(link.req_write),
    .req_reg(link.req_reg), .req_addr(link.req_addr), .req_wdata(link.req_wdata), .ack(link.ack),
    .busy_o(busy), .flags_o(flags));
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  // a stuck handshake must not hang the run
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      wrap_up();
    end
  end
  // --------------
  // checking and bus tasks
  // --------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wrap_up;
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // aw and w offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready    <= 1'b0;
    resp_seen = {30'h0, bresp};
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge mclk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready    <= 1'b0;
    rd_seen   = rdata;
    resp_seen = {30'h0, rresp};
  endtask : axi_rd
  // one link request, polled until answered
  task automatic link_go(input logic [31:0] ctl);
    axi_wr(H_OFS_CTRL, ctl);
    do axi_rd(H_OFS_STATUS); while (rd_seen[STS_BUSY] !== 1'b0);
  endtask : link_go
  task automatic dev_wr(input logic [7:0] off, input logic [31:0] d);
    axi_wr(H_OFS_TARGET, {16'h0001, 8'h00, off});
    axi_wr(H_OFS_WDATA, d);
    link_go(32'h3);
  endtask : dev_wr
  task automatic dev_rd(input logic [16:0] t);
    axi_wr(H_OFS_TARGET, {15'h0, t});
    link_go(32'h1);
    axi_rd(H_OFS_RDATA);
  endtask : dev_rd
  task automatic cmd(input logic [7:0] code);
    dev_wr(OFS_COMMAND, {24'h0, code});
  endtask : cmd
  // wait for done or unknown, clear started before done
  task automatic settle(input logic [3:0] exp);
    rd_seen = '0;
    while (rd_seen[FLG_DONE] !== 1'b1 && rd_seen[FLG_UNKNOWN] !== 1'b1) dev_rd({9'h100, OFS_EVENTS});
    chk("event flags", rd_seen, {28'h0, exp});
    dev_wr(OFS_EVENTS, 32'h2);
    dev_wr(OFS_EVENTS, 32'hd);
    dev_rd({9'h100, OFS_EVENTS});
    chk("flags cleared", rd_seen, 32'h0);
  endtask : settle
  // --------------
  // scenarios
  // --------------
  task automatic t_regs;
    dev_rd({9'h100, OFS_SIZE});
    chk("size", rd_seen, SIZE_VALUE);
    axi_wr(8'h20, 32'h0);
    chk("unmapped bresp", resp_seen, {30'h0, RESP_SLVERR});
    axi_rd(8'h20);
    chk("unmapped rresp", resp_seen, {30'h0, RESP_SLVERR});
  endtask : t_regs
  // the first array read lands mid-erase and must wait
  task automatic t_mass;
    cmd(CMD_FULL_CLEAR);
    dev_rd({1'b0, 16'h0});
    chk("word 0 cleared", rd_seen, ERASED_WORD);
    settle(4'h3);
    dev_rd({1'b0, LAST_WORD});
    chk("last word cleared", rd_seen, ERASED_WORD);
  endtask : t_mass
  task automatic t_prog;
    dev_wr(OFS_ADDRESS, {16'h0, A1});
    dev_wr(OFS_PROGRAM_WORD_FIRST, 32'h1234_5678);
    cmd(CMD_ONE_WORD);
    settle(4'h3);
    dev_rd({1'b0, A1});
    chk("single word", rd_seen, 32'h1234_5678);
    dev_wr(OFS_PROGRAM_WORD_FIRST, 32'hff00_ff0f);
    cmd(CMD_ONE_WORD);
    settle(4'h3);
    dev_rd({1'b0, A1});
    chk("anded word", rd_seen, 32'h1234_5678 & 32'hff00_ff0f);
    dev_rd({1'b0, A1 + 16'h1});
    chk("neighbour untouched", rd_seen, ERASED_WORD);
  endtask : t_prog
  // data word 2 left all ones is skipped
  task automatic t_burst;
    dev_wr(OFS_ADDRESS, {16'h0, A2});
    for (int i = 0; i < 4; i++) dev_wr(OFS_PROGRAM_WORD_FIRST + 8'(4 * i), (i == 2) ? ERASED_WORD : 32'ha5a5_0000 + 32'(i));
    cmd(CMD_MULTI_WORD);
    settle(4'h3);
    for (int i = 0; i < 4; i++) begin
      dev_rd({1'b0, A2 + 16'(i)});
      chk("burst word", rd_seen, (i == 2) ? ERASED_WORD : 32'ha5a5_0000 + 32'(i));
    end
  endtask : t_burst
  task automatic t_page;
    dev_wr(OFS_ADDRESS, {16'h0, A1[15:9], 9'h0});
    cmd(CMD_PAGE_CLEAR);
    settle(4'h3);
    dev_rd({1'b0, A1});
    chk("cleared page", rd_seen, ERASED_WORD);
    dev_rd({1'b0, A2});
    chk("other page kept", rd_seen, 32'ha5a5_0000);
  endtask : t_page
  // a full clear during a page clear is refused and flagged
  task automatic t_errors;
    cmd(8'h55);
    settle(4'h8);
    dev_wr(OFS_ADDRESS, {16'h0, 7'd5, 9'h0});
    cmd(CMD_PAGE_CLEAR);
    cmd(CMD_FULL_CLEAR);
    settle(4'h7);
    dev_rd({1'b0, A2});
    chk("busy command ignored", rd_seen, 32'ha5a5_0000);
  endtask : t_errors
  initial begin
    arst_n_i = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    repeat (16) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_mass();
    t_prog();
    t_burst();
    t_page();
    t_errors();
    wrap_up();
  end
endmodule : tb_embedded_flash_controller
